//--- mfd_pkg.sv
// Package of field positions, encodings and timing for the mode field decoder.
package mfd_pkg;
  // Mode register selectors on the bank bits.
  localparam logic [2:0] MFD_BANK_MW0 = 3'h0;
  localparam logic [2:0] MFD_BANK_MW1 = 3'h1;
  localparam logic [2:0] MFD_BANK_MW2 = 3'h2;
  // Mode word zero field positions.
  localparam int MFD_MW0_CL0 = 2;
  localparam int MFD_MW0_CL_LO = 4;
  localparam int MFD_MW0_CL_HI = 6;
  localparam int MFD_MW0_TEST = 7;
  localparam int MFD_MW0_LRST = 8;
  localparam int MFD_MW0_WR_LO = 9;
  localparam int MFD_MW0_WR_HI = 11;
  localparam int MFD_MW0_PPD = 12;
  // Mode word one field positions.
  localparam int MFD_MW1_LOOP_OFF = 0;
  localparam int MFD_MW1_DRV0 = 1;
  localparam int MFD_MW1_RTT0 = 2;
  localparam int MFD_MW1_AL_LO = 3;
  localparam int MFD_MW1_AL_HI = 4;
  localparam int MFD_MW1_DRV1 = 5;
  localparam int MFD_MW1_RTT1 = 6;
  localparam int MFD_MW1_WLEV = 7;
  localparam int MFD_MW1_RTT2 = 9;
  localparam int MFD_MW1_QOFF = 12;
  // Mode word two field positions.
  localparam int MFD_MW2_PAR_LO = 0;
  localparam int MFD_MW2_PAR_HI = 2;
  localparam int MFD_MW2_CWL_LO = 3;
  localparam int MFD_MW2_CWL_HI = 5;
  localparam int MFD_MW2_RTTW_LO = 9;
  localparam int MFD_MW2_RTTW_HI = 10;
  // Posted delay codes.
  localparam logic [1:0] MFD_AL_ZERO = 2'h0;
  localparam logic [1:0] MFD_AL_M1 = 2'h1;
  localparam logic [1:0] MFD_AL_M2 = 2'h2;
  // Latency code bases and the write recovery table.
  localparam logic [4:0] MFD_CL_BASE = 5'h4;
  localparam logic [4:0] MFD_CWL_BASE = 5'h5;
  localparam logic [4:0] MFD_WR_BASE = 5'h4;
  localparam logic [4:0] MFD_WR_STEP = 5'h2;
  localparam logic [4:0] MFD_WR_CODE0 = 5'h10;
  // Reset values of the mode words.
  localparam logic [13:0] MFD_MW_RST = 14'h0000;
  // Loop lock time in clock cycles.
  localparam int MFD_LOCK_CYC = 512;
  localparam logic [9:0] MFD_LOCK_CNT = 10'(MFD_LOCK_CYC);
  // Shift depth of the command delay line.
  localparam int MFD_DLY_W = 32;
endpackage

//--- mfd_cmd_if.sv
// Interface carrying decoded command strobes to the delay line.
`timescale 1ns/100ps
interface mfd_cmd_if;
  logic rd_in;
  logic wr_in;
  logic [4:0] al;
  logic rd_out;
  logic wr_out;
  modport ctl (output rd_in, output wr_in, output al, input rd_out,
    input wr_out);
  modport dly (input rd_in, input wr_in, input al, output rd_out,
    output wr_out);
endinterface

//--- mfd_post_delay.sv
// Posted command delay line for reads and writes.
`timescale 1ns/100ps
module mfd_post_delay
  import mfd_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Command strobes.
  mfd_cmd_if.dly cmd
);
  typedef struct packed {
    logic [MFD_DLY_W-1:0] rd_sr;
    logic [MFD_DLY_W-1:0] wr_sr;
  } mfd_dly_t;
  mfd_dly_t st_reg, st_next;

  // Shift commands in; a zero delay passes them straight through.
  always_comb begin
    st_next = st_reg;
    st_next.rd_sr = {st_reg.rd_sr[MFD_DLY_W-2:0], cmd.rd_in};
    st_next.wr_sr = {st_reg.wr_sr[MFD_DLY_W-2:0], cmd.wr_in};
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Tap selection: tap n-1 of the line is n cycles late.
  assign cmd.rd_out = (cmd.al == 5'h0) ? cmd.rd_in
                    : st_reg.rd_sr[cmd.al - 5'h1]; // R17
  assign cmd.wr_out = (cmd.al == 5'h0) ? cmd.wr_in
                    : st_reg.wr_sr[cmd.al - 5'h1]; // R17
endmodule

//--- mfd_top.sv
// Mode word decoder: latencies, loop control, termination, output disable.
// Contract
// R1: Read access delay from word zero bits.
// R2: Only whole-clock latencies exist.
// R3: Total read delay is posted plus access.
// R4: Controller keeps test bit zero.
// R5: Loop reset bit clears itself.
// R6: Controller waits lock time after loop reset.
// R7: Recovery field forms precharge done delay.
// R8: Power-down bit selects frozen or running loop.
// R9: Controller writes word one with reserved zeros.
// R10: Write leveling limits nominal termination values.
// R11: Nominal termination in writes limited values.
// R12: Loop off in self refresh, back after.
// R13: Controller holds clock enable during lock.
// R14: Controller disables termination while loop off.
// R15: Controller clears write termination while loop off.
// R16: Write termination works without nominal termination.
// R17: Commands delayed by posted command delay.
// R18: Output disable bit disconnects data outputs.
// R19: Controller writes word two with reserved zeros.
// R20: No write termination during write leveling.
// R21: Partial refresh loses data only in self refresh.
// R22: Write delay from word two, plus posted.
// R23: Controller changes mode words only when idle.
`timescale 1ns/100ps
module mfd_top
  import mfd_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Mode register set command.
  input wire logic mrs_valid,
  input wire logic [2:0] mrs_bank,
  input wire logic [13:0] mrs_addr,
  // Array commands and power states.
  input wire logic rd_cmd,
  input wire logic wr_cmd,
  input wire logic self_refresh,
  input wire logic pd_active,
  input wire logic odt_in,
  // Decoded latencies in clock cycles.
  output logic [4:0] read_access_delay,
  output logic [4:0] write_access_delay,
  output logic [4:0] posted_command_delay,
  output logic [5:0] total_read_delay,
  output logic [5:0] total_write_delay,
  output logic [5:0] precharge_done_delay,
  // Loop and output control.
  output logic loop_running,
  output logic loop_locked,
  output logic test_mode,
  output logic out_disable,
  output logic [1:0] drive_sel,
  output logic [2:0] rtt_active,
  output logic rtt_is_write,
  output logic [2:0] partial_array_refresh,
  output logic write_leveling,
  // Delayed internal commands.
  output logic rd_internal,
  output logic wr_internal
);
  typedef struct packed {
    logic [13:0] mw0;
    logic [13:0] mw1;
    logic [13:0] mw2;
    logic [9:0] lock_cnt;
    logic [2:0] rtt;
    logic rtt_wr;
  } mfd_state_t;
  mfd_state_t st_reg, st_next;

  mfd_cmd_if cmd_bus ();

  // Read access delay: three-bit code plus low extension bit.
  function automatic logic [4:0] cl_decode(input logic [13:0] w);
    logic [3:0] code;
    code = {w[MFD_MW0_CL_HI:MFD_MW0_CL_LO], w[MFD_MW0_CL0]};
    cl_decode = MFD_CL_BASE + 5'(code); // R1 R2
  endfunction

  // Posted delay from the two-bit code and the read access delay.
  function automatic logic [4:0] al_decode(input logic [1:0] c,
    input logic [4:0] cl);
    unique case (c)
      MFD_AL_ZERO: al_decode = 5'h0;
      MFD_AL_M1: al_decode = cl - 5'h1;
      MFD_AL_M2: al_decode = cl - 5'h2;
      default: al_decode = 5'h0; // Reserved code gives no delay.
    endcase
  endfunction

  logic [4:0] cl_w, cwl_w, al_w, wr_w;
  logic [2:0] wr_code;
  logic loop_en;
  always_comb begin
    cl_w = cl_decode(st_reg.mw0);
    cwl_w = MFD_CWL_BASE
          + 5'(st_reg.mw2[MFD_MW2_CWL_HI:MFD_MW2_CWL_LO]); // R22
    al_w = al_decode(st_reg.mw1[MFD_MW1_AL_HI:MFD_MW1_AL_LO],
                     cl_w); // R17
    wr_code = st_reg.mw0[MFD_MW0_WR_HI:MFD_MW0_WR_LO];
    // Code zero stands for the longest recovery of the table.
    wr_w = (wr_code == 3'h0) ? MFD_WR_CODE0
         : ((wr_code < 3'h4) ? MFD_WR_BASE + 5'(wr_code)
         : MFD_WR_BASE + 5'(wr_code) + 5'(wr_code) - MFD_WR_STEP - 5'h2); // R7
    // Loop runs when enabled, outside self refresh, and not frozen.
    loop_en = !st_reg.mw1[MFD_MW1_LOOP_OFF] && !self_refresh // R12
      && !(pd_active && !st_reg.mw0[MFD_MW0_PPD]); // R8
  end

  // Register mode words, self-clear loop reset, count lock, pick termination.
  always_comb begin
    st_next = st_reg;
    st_next.mw0[MFD_MW0_LRST] = 1'b0; // R5
    if (mrs_valid && mrs_bank == MFD_BANK_MW0) begin
      st_next.mw0 = mrs_addr;
    end else if (mrs_valid && mrs_bank == MFD_BANK_MW1) begin
      st_next.mw1 = mrs_addr;
    end else if (mrs_valid && mrs_bank == MFD_BANK_MW2) begin
      st_next.mw2 = mrs_addr;
    end
    // A reset or a stopped loop restarts the lock wait.
    if (st_reg.mw0[MFD_MW0_LRST] || !loop_en) begin
      st_next.lock_cnt = MFD_LOCK_CNT;
    end else if (st_reg.lock_cnt != 10'h0) begin
      st_next.lock_cnt = st_reg.lock_cnt - 10'h1;
    end
    // Write termination applies on writes even with nominal off,
    // but never during write leveling, which keeps nominal only.
    if (odt_in && wr_cmd && !st_reg.mw1[MFD_MW1_WLEV] // R20
        && st_reg.mw2[MFD_MW2_RTTW_HI:MFD_MW2_RTTW_LO] != 2'h0) begin // R16
      st_next.rtt = {1'b0, st_reg.mw2[MFD_MW2_RTTW_HI:MFD_MW2_RTTW_LO]};
      st_next.rtt_wr = 1'b1;
    end else if (odt_in) begin
      st_next.rtt = {st_reg.mw1[MFD_MW1_RTT2], st_reg.mw1[MFD_MW1_RTT1],
                     st_reg.mw1[MFD_MW1_RTT0]};
      st_next.rtt_wr = 1'b0;
    end else begin
      st_next.rtt = 3'h0;
      st_next.rtt_wr = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= '{MFD_MW_RST, MFD_MW_RST, MFD_MW_RST, MFD_LOCK_CNT,
                  3'h0, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Posted command delay line.
  assign cmd_bus.rd_in = rd_cmd;
  assign cmd_bus.wr_in = wr_cmd;
  assign cmd_bus.al = al_w;
  mfd_post_delay u_dly (
    .clock(clock),
    .nrst(nrst),
    .cmd(cmd_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs; all but the loop and internal command outputs come from the state register through field decode.
  assign read_access_delay = cl_w;
  assign write_access_delay = cwl_w;
  assign posted_command_delay = al_w;
  assign total_read_delay = 6'(al_w) + 6'(cl_w); // R3
  assign total_write_delay = 6'(al_w) + 6'(cwl_w); // R22
  assign precharge_done_delay = 6'(wr_w) + 6'(cl_w); // R7
  assign loop_running = loop_en;
  assign loop_locked = loop_en && st_reg.lock_cnt == 10'h0;
  assign test_mode = st_reg.mw0[MFD_MW0_TEST];
  assign out_disable = st_reg.mw1[MFD_MW1_QOFF]; // R18
  assign drive_sel = {st_reg.mw1[MFD_MW1_DRV1], st_reg.mw1[MFD_MW1_DRV0]};
  assign rtt_active = st_reg.rtt;
  assign rtt_is_write = st_reg.rtt_wr;
  // Refresh range only matters on self refresh entry.
  assign partial_array_refresh = st_reg.mw2[MFD_MW2_PAR_HI:MFD_MW2_PAR_LO]; // R21
  assign write_leveling = st_reg.mw1[MFD_MW1_WLEV];
  // Internal commands are suppressed nowhere; reads wait on lock outside.
  assign rd_internal = cmd_bus.rd_out; // R17
  assign wr_internal = cmd_bus.wr_out; // R17

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_loop_reset_clear: assert property (@(posedge clock) disable iff (!nrst)
    (mrs_valid && mrs_bank == MFD_BANK_MW0 && mrs_addr[MFD_MW0_LRST])
    |=> ##1 !st_reg.mw0[MFD_MW0_LRST] || mrs_valid) // R5
    else $error("loop reset bit did not clear");
  chk_read_sum: assert property (@(posedge clock) disable iff (!nrst)
    total_read_delay == 6'(posted_command_delay) + 6'(read_access_delay)) // R3
    else $error("total read delay wrong");
  chk_write_sum: assert property (@(posedge clock) disable iff (!nrst)
    total_write_delay == 6'(posted_command_delay) + 6'(write_access_delay)) // R22
    else $error("total write delay wrong");
  chk_self_ref_loop: assert property (@(posedge clock) disable iff (!nrst)
    self_refresh |-> !loop_running) // R12
    else $error("loop ran in self refresh");
  chk_qoff_bit: assert property (@(posedge clock) disable iff (!nrst)
    (mrs_valid && mrs_bank == MFD_BANK_MW1)
    |=> out_disable == $past(mrs_addr[MFD_MW1_QOFF])) // R18
    else $error("output disable not taken");
  chk_wlev_no_wtt: assert property (@(posedge clock) disable iff (!nrst)
    write_leveling |=> !rtt_is_write) // R20
    else $error("write termination in leveling");
  chk_al_zero_pass: assert property (@(posedge clock) disable iff (!nrst)
    (posted_command_delay == 5'h0 && rd_cmd) |-> rd_internal) // R17
    else $error("zero delay read not passed");
  chk_al_one_delay: assert property (@(posedge clock) disable iff (!nrst)
    (posted_command_delay == 5'h3 && rd_cmd && !mrs_valid)
    ##1 !mrs_valid ##1 !mrs_valid
    |=> rd_internal) // R17
    else $error("posted read not delayed");
  chk_ppd_freeze: assert property (@(posedge clock) disable iff (!nrst)
    (pd_active && !st_reg.mw0[MFD_MW0_PPD]) |-> !loop_running) // R8
    else $error("loop not frozen in slow exit");
  cov_loop_lock: cover property (@(posedge clock) disable iff (!nrst)
    $rose(loop_locked));
  cov_write_tt: cover property (@(posedge clock) disable iff (!nrst)
    rtt_is_write);
  cov_posted_rd: cover property (@(posedge clock) disable iff (!nrst)
    rd_internal && posted_command_delay != 5'h0);
endmodule

//--- mfd_ctl_model.sv
// Controller model that issues mode register set commands to the decoder.
`timescale 1ns/100ps
module mfd_ctl_model
  import mfd_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Mode register set command.
  output logic mrs_valid,
  output logic [2:0] mrs_bank,
  output logic [13:0] mrs_addr
);
  initial begin
    mrs_valid = 1'b0;
    mrs_bank = 3'h7;
    mrs_addr = 14'h0000;
  end
  // Reserved bits are forced low; raw lets a scenario set the test bit.
  // The lines are inverted after use so a stale value never looks valid.
  task automatic mrs(input logic [2:0] b, input logic [13:0] a,
      input bit raw);
    logic [13:0] m;
    m = a & 14'h1FFF;
    if (b == MFD_BANK_MW0 && !raw) m[7] = 1'b0;
    if (b == MFD_BANK_MW1) m = m & 14'h12FF;
    if (b == MFD_BANK_MW2) m = m & 14'h06FF;
    @(negedge clock);
    mrs_valid = 1'b1;
    mrs_bank = b;
    mrs_addr = m;
    @(negedge clock);
    mrs_valid = 1'b0;
    mrs_bank = ~b;
    mrs_addr = ~m;
    @(negedge clock);
  endtask
endmodule

//--- tb_top.sv
// Self-checking testbench for the mode field decoder.
`timescale 1ns/100ps
module tb_top;
  import mfd_pkg::*;
  logic clock = 0, nrst = 0, rd_cmd = 0, wr_cmd = 0;
  logic self_refresh = 0, pd_active = 0, odt_in = 0;
  logic mrs_valid, rd_internal, wr_internal;
  logic [2:0] mrs_bank;
  logic [13:0] mrs_addr, a0, a1, a2;
  logic [4:0] rcl, wcl, pcd, cl, al;
  logic [5:0] trd, twd, pdd;
  logic running, locked, tmode, odis, wlev, rtt_w;
  logic [1:0] drv;
  logic [2:0] rtt, par;
  int n_fail = 0, tests_run = 0, k;
  always #12.5 clock = ~clock;
  mfd_ctl_model mfd_ctl_model_i (.clock(clock), .mrs_valid(mrs_valid),
    .mrs_bank(mrs_bank), .mrs_addr(mrs_addr));
  mfd_top mfd_top_i (.clock(clock), .nrst(nrst), .mrs_valid(mrs_valid),
    .mrs_bank(mrs_bank), .mrs_addr(mrs_addr), .rd_cmd(rd_cmd),
    .wr_cmd(wr_cmd), .self_refresh(self_refresh), .pd_active(pd_active),
    .odt_in(odt_in), .read_access_delay(rcl), .write_access_delay(wcl),
    .posted_command_delay(pcd), .total_read_delay(trd),
    .total_write_delay(twd), .precharge_done_delay(pdd),
    .loop_running(running), .loop_locked(locked), .test_mode(tmode),
    .out_disable(odis), .drive_sel(drv), .rtt_active(rtt),
    .rtt_is_write(rtt_w), .partial_array_refresh(par),
    .write_leveling(wlev), .rd_internal(rd_internal),
    .wr_internal(wr_internal));
  ////////////////////////////////////////////////////////////////////////
  // Compare one value against its expectation.
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Closing task shared by the main sequence and the watchdog.
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Write recovery code to cycles; code zero is the longest setting.
  function automatic logic [5:0] f_wr(input logic [2:0] c);
    return (c == 0) ? 6'h10 : (c < 5) ? 6'(c) + 6'h4 : 6'(c) * 6'h2;
  endfunction
  // Count cycles from a command strobe to its internal copy.
  task automatic dly(input bit w, input logic [4:0] exp);
    k = 0;
    @(negedge clock);
    if (w) wr_cmd = 1'b1;
    else rd_cmd = 1'b1;
    #1;
    while ((w ? wr_internal : rd_internal) !== 1'b1 && k < 40) begin
      @(negedge clock);
      rd_cmd = 1'b0;
      wr_cmd = 1'b0;
      k++;
      #1;
    end
    rd_cmd = 1'b0;
    wr_cmd = 1'b0;
    chk(6'(k), 6'(exp));
  endtask
  // Program termination, strobe a write and check the chosen value.
  task automatic term(input logic [13:0] m1, input logic [13:0] m2,
      input logic [2:0] exp, input logic isw);
    mfd_ctl_model_i.mrs(MFD_BANK_MW1, m1, 0);
    mfd_ctl_model_i.mrs(MFD_BANK_MW2, m2, 0);
    wr_cmd = 1'b1;
    @(negedge clock);
    wr_cmd = 1'b0;
    #1;
    chk(6'(rtt), 6'(exp));
    chk(6'(rtt_w), 6'(isw));
  endtask
  // Wait for lock and check that it took the lock time.
  task automatic lockw;
    k = 0;
    // Power-down stays low so clock enable is held through the wait.
    pd_active = 1'b0;
    while (locked !== 1'b1 && k < 700) begin
      @(negedge clock);
      k++;
    end
    chk(6'(k > 500 && k < 516), 6'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up;
  end
  // Main sequence; mode sets are only issued with no access in flight.
  initial begin
    void'($urandom(80377));
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    #1;
    chk(6'(rcl), 6'h4);
    chk(6'(pcd), 6'h0);
    chk(6'(locked), 6'h0);
    lockw();
    $display("test reset done");
    for (int i = 0; i < 20; i++) begin
      a0 = 14'($urandom) & 14'h1E74;
      a1 = (14'($urandom) & 14'h1262) | 14'(i % 4 << 3);
      a2 = 14'($urandom) & 14'h063F;
      cl = 5'h4 + 5'({a0[6], a0[5], a0[4], a0[2]});
      al = (i % 4 == 1) ? cl - 5'h1 : (i % 4 == 2) ? cl - 5'h2 : 5'h0;
      mfd_ctl_model_i.mrs(MFD_BANK_MW0, a0, 0);
      mfd_ctl_model_i.mrs(MFD_BANK_MW1, a1, 0);
      mfd_ctl_model_i.mrs(MFD_BANK_MW2, a2, 0);
      mfd_ctl_model_i.mrs(3'h3, 14'h0, 0);
      chk(6'(rcl), 6'(cl));
      chk(6'(pcd), 6'(al));
      chk(trd, 6'(al) + 6'(cl));
      chk(twd, 6'(al) + 6'h5 + 6'(a2[5:3]));
      chk(6'(wcl), 6'h5 + 6'(a2[5:3]));
      chk(6'(tmode), 6'h0);
      chk(pdd, f_wr(a0[11:9]) + 6'(cl));
      chk(6'(odis), 6'(a1[12]));
      chk(6'({par, drv}), 6'({a2[2:0], a1[5], a1[1]}));
      dly(0, al);
      dly(1, al);
    end
    $display("test decode done");
    odt_in = 1'b1;
    term(14'h0204, 14'h0200, 3'h1, 1'b1);
    term(14'h0000, 14'h0400, 3'h2, 1'b1);
    term(14'h0284, 14'h0400, 3'h5, 1'b0);
    chk(6'(wlev), 6'h1);
    $display("test termination done");
    odt_in = 1'b0;
    mfd_ctl_model_i.mrs(MFD_BANK_MW2, 14'h0000, 0);
    chk(6'(rtt), 6'h0);
    self_refresh = 1'b1;
    @(negedge clock);
    chk(6'(running), 6'h0);
    self_refresh = 1'b0;
    @(negedge clock);
    chk(6'(running), 6'h1);
    lockw();
    mfd_ctl_model_i.mrs(MFD_BANK_MW0, 14'h1000, 0);
    pd_active = 1'b1;
    @(negedge clock);
    chk(6'(running), 6'h1);
    mfd_ctl_model_i.mrs(MFD_BANK_MW0, 14'h0100, 0);
    chk(6'(running), 6'h0);
    pd_active = 1'b0;
    lockw();
    $display("test loop done");
    wrap_up;
  end
endmodule
